// File: include/dcf_defs.svh
// constants for the deep first-in first-out buffer block
// assumes inclusion by bare name from the package and the design modules
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define DCF_WORD_W 18
`define DCF_OFS_W 16
`define DCF_CMP_W 17

// ****************************************************************
// capacity limits and reset values
// ****************************************************************
`define DCF_DEPTH_DEFAULT 8192
`define DCF_DEPTH_MIN 256
`define DCF_DEPTH_MAX 65536
`define DCF_OFS_RESET 16'h007f

`endif

// File: include/dcf_pkg.sv
// shared types of the deep first-in first-out buffer block
// assumes dcf_defs.svh is reachable on the include path
`include "dcf_defs.svh"

package dcf_pkg;

	typedef logic [`DCF_WORD_W-1:0] dcf_word_t;
	typedef logic [`DCF_OFS_W-1:0] dcf_ofs_t;

	// which offset register the next load or readback touches
	typedef enum logic {
		dcf_sel_empty,
		dcf_sel_full
	} dcf_sel_t;

endpackage : dcf_pkg

// File: hdl/dcf_store.sv
// word array of the buffer: one write port, one combinational read port
// assumes the caller never writes and reads one address in one cycle
// with a need for the new value
`include "dcf_defs.svh"

module dcf_store #(
	parameter int DEPTH = `DCF_DEPTH_DEFAULT,
	parameter int AW = $clog2(`DCF_DEPTH_DEFAULT)
) (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire dcf_pkg::dcf_word_t wr_data,
	input wire logic [AW-1:0] rd_addr,
	output dcf_pkg::dcf_word_t rd_data
);
	import dcf_pkg::*;

	dcf_word_t mem [DEPTH];

	generate
		if ((1 << AW) != DEPTH)
		begin : g_bad
			$error("dcf_store: DEPTH must equal 2**AW");
		end
	endgenerate

	// array has no reset: contents are only seen after a push
	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule : dcf_store

// File: hdl/dcf_fifo.sv
// deep first-in first-out buffer with flags, offsets, replay and chaining
// assumes push and pop sides share sys_clk; inputs synchronous to it
//
// Operation
// - stores DEPTH words of eighteen bits each
// - clear empties buffer and resets all pointers
// - clear drives read_word low when output enabled
// - push captures write_word when not full
// - pop presents next stored word when not empty
// - disabled output enable floats read_word
// - pushes ignored when full, pops when empty
// - empty buffer holds last popped word
// - no_room_n low at full, on a push or replay edge
// - nothing_stored_n low at empty, on a pop, replay or clear edge
// - two sixteen-bit offsets loaded from write_word
// - offset writes alternate empty then full offset
// - loading may pause; sequence continues later
// - offset readback alternates likewise on pop edges
// - both offsets default to 127
// - near flags assert at or below offset
// - flag_sync_select low makes near flags clocked
// - over_half_n low above half capacity
// - chained mode: over_half_n carries push token
// - replay_strobe rewinds read pointer to start, outside chained mode only
`include "dcf_defs.svh"

module dcf_fifo #(
	parameter int DEPTH = `DCF_DEPTH_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clear_n,
	input wire dcf_pkg::dcf_word_t write_word,
	input wire logic push_enable_n,
	input wire logic pop_enable_n,
	input wire logic offset_load_n,
	input wire logic output_drive_enable_n,
	input wire logic flag_sync_select,
	input wire logic replay_strobe,
	input wire logic cascade_mode,
	input wire logic chain_head_n,
	input wire logic push_token_in,
	input wire logic pop_token_in,
	output dcf_pkg::dcf_word_t read_word_o,
	output logic read_word_oe,
	output logic nothing_stored_n,
	output logic no_room_n,
	output logic near_empty_n,
	output logic near_full_n,
	output logic over_half_n,
	output logic pop_token_out
);
	import dcf_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int CMPW = `DCF_CMP_W;

	generate
		if (DEPTH < `DCF_DEPTH_MIN || DEPTH > `DCF_DEPTH_MAX ||
			(1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("dcf_fifo: DEPTH must be a power of two in range");
		end
	endgenerate

	// ****************************************************************
	// pointers and count
	// ****************************************************************
	logic wipe;
	logic [CW-1:0] wr_ptr;
	logic [CW-1:0] rd_ptr;
	logic [CW-1:0] next_wr;
	logic [CW-1:0] next_rd;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic push_ok;
	logic pop_ok;
	logic replay;
	logic write_held;
	logic read_held;
	logic push_token_n;
	logic empty_hit_reg;
	logic full_hit_reg;
	logic half_n_reg;
	dcf_ofs_t almost_empty_distance;
	dcf_ofs_t almost_full_distance;
	dcf_sel_t wsel;
	dcf_sel_t rsel;
	dcf_word_t rd_data;

	assign wipe = !rst_n || !clear_n;
	// replay only exists outside chained mode
	assign replay = replay_strobe && !cascade_mode;
	// flags gate the enables so nothing over- or underflows
	assign push_ok = !push_enable_n && offset_load_n && no_room_n &&
		(write_held || !cascade_mode);
	assign pop_ok = !pop_enable_n && offset_load_n && nothing_stored_n &&
		(read_held || !cascade_mode) && !replay;

	assign next_wr = wr_ptr + CW'(push_ok);
	assign next_rd = replay ? '0 : rd_ptr + CW'(pop_ok);
	assign count = wr_ptr - rd_ptr;
	assign next_count = next_wr - next_rd;

	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr;
			rd_ptr <= next_rd;
		end
	end

	dcf_store #(
		.DEPTH(DEPTH),
		.AW(AW)
	) i_dcf_store (
		.sys_clk(sys_clk),
		.wr_en(push_ok),
		.wr_addr(wr_ptr[AW-1:0]),
		.wr_data(write_word),
		.rd_addr(rd_ptr[AW-1:0]),
		.rd_data(rd_data)
	);

	// ****************************************************************
	// boundary flags
	// ****************************************************************
	// flags follow the count after the edge, so they never lag a transfer
	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			nothing_stored_n <= 1'b0;
			no_room_n <= 1'b1;
			half_n_reg <= 1'b1;
			empty_hit_reg <= 1'b1;
			full_hit_reg <= 1'b0;
		end
		else
		begin
			nothing_stored_n <= next_count != '0;
			no_room_n <= next_count != CW'(DEPTH);
			half_n_reg <= !(next_count > CW'(DEPTH / 2));
			empty_hit_reg <= CMPW'(next_count) <=
				CMPW'(almost_empty_distance);
			full_hit_reg <= CMPW'(CW'(DEPTH) - next_count) <=
				CMPW'(almost_full_distance);
		end
	end

	// unclocked variant follows a fresh offset load without an edge
	always_comb
	begin
		if (flag_sync_select)
		begin
			near_empty_n = !(CMPW'(count) <=
				CMPW'(almost_empty_distance));
			near_full_n = !(CMPW'(CW'(DEPTH) - count) <=
				CMPW'(almost_full_distance));
		end
		else
		begin
			near_empty_n = !empty_hit_reg;
			near_full_n = !full_hit_reg;
		end
	end

	assign over_half_n = cascade_mode ? push_token_n : half_n_reg;

	// ****************************************************************
	// offset registers
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			almost_empty_distance <= `DCF_OFS_RESET;
			almost_full_distance <= `DCF_OFS_RESET;
			wsel <= dcf_sel_empty;
		end
		else if (!offset_load_n && !push_enable_n)
		begin
			unique case (wsel)
				dcf_sel_empty:
				begin
					almost_empty_distance <= write_word[`DCF_OFS_W-1:0];
					wsel <= dcf_sel_full;
				end
				dcf_sel_full:
				begin
					almost_full_distance <= write_word[`DCF_OFS_W-1:0];
					wsel <= dcf_sel_empty;
				end
			endcase
		end
	end

	// selection survives offset_load_n going high so a later load resumes
	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			rsel <= dcf_sel_empty;
		end
		else if (!offset_load_n && !pop_enable_n)
		begin
			rsel <= (rsel == dcf_sel_empty) ? dcf_sel_full :
				dcf_sel_empty;
		end
	end

	// ****************************************************************
	// output register and drive
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			read_word_o <= '0;
		end
		else if (!offset_load_n && !pop_enable_n)
		begin
			read_word_o <= (rsel == dcf_sel_empty) ?
				dcf_word_t'(almost_empty_distance) :
				dcf_word_t'(almost_full_distance);
		end
		else if (pop_ok)
		begin
			read_word_o <= rd_data;
		end
	end

	// chained devices only drive while they own the read side
	assign read_word_oe = !output_drive_enable_n &&
		(read_held || !cascade_mode);

	// ****************************************************************
	// chain tokens
	// ****************************************************************
	// head of chain starts owning both sides; token moves after last slot
	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			write_held <= !chain_head_n;
			push_token_n <= 1'b1;
		end
		else
		begin
			push_token_n <= !(cascade_mode && push_ok &&
				wr_ptr[AW-1:0] == '1);
			if (push_ok && wr_ptr[AW-1:0] == '1)
			begin
				write_held <= 1'b0;
			end
			else if (!push_token_in)
			begin
				write_held <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (wipe)
		begin
			read_held <= !chain_head_n;
			pop_token_out <= 1'b1;
		end
		else
		begin
			pop_token_out <= !(cascade_mode && pop_ok &&
				rd_ptr[AW-1:0] == '1);
			if (pop_ok && rd_ptr[AW-1:0] == '1)
			begin
				read_held <= 1'b0;
			end
			else if (!pop_token_in)
			begin
				read_held <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_clear_empty;
		!clear_n |=> !nothing_stored_n && count == '0 && no_room_n;
	endproperty
	a_clear_empty: assert property (p_clear_empty)
		else $error("clear did not empty the buffer");

	property p_clear_low;
		!clear_n |=> read_word_o == '0;
	endproperty
	a_clear_low: assert property (p_clear_low)
		else $error("read word not low after clear");

	property p_float;
		output_drive_enable_n |-> !read_word_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("read word driven while output disabled");

	property p_push_count;
		push_ok && !pop_ok && !replay && clear_n |=>
			count == $past(count) + CW'(1);
	endproperty
	a_push_count: assert property (p_push_count)
		else $error("push did not add one word");

	property p_pop_data;
		pop_ok && clear_n |=> read_word_o == $past(rd_data);
	endproperty
	a_pop_data: assert property (p_pop_data)
		else $error("pop did not present stored word");

	property p_no_overflow;
		!no_room_n && !pop_ok && !replay && clear_n |=>
			count == CW'(DEPTH) && !no_room_n;
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("full buffer accepted a push");

	property p_hold_empty;
		!nothing_stored_n && offset_load_n && clear_n |=>
			$stable(read_word_o);
	endproperty
	a_hold_empty: assert property (p_hold_empty)
		else $error("empty buffer changed read word");

	property p_full_flag;
		!no_room_n == (count == CW'(DEPTH));
	endproperty
	a_full_flag: assert property (p_full_flag)
		else $error("full flag disagrees with count");

	property p_empty_flag;
		!nothing_stored_n == (count == '0);
	endproperty
	a_empty_flag: assert property (p_empty_flag)
		else $error("empty flag disagrees with count");

	property p_ofs_seq;
		!offset_load_n && !push_enable_n && clear_n &&
			wsel == dcf_sel_empty |=>
			almost_empty_distance == $past(write_word[`DCF_OFS_W-1:0]) &&
			wsel == dcf_sel_full;
	endproperty
	a_ofs_seq: assert property (p_ofs_seq)
		else $error("offset load went to the wrong register");

	property p_default_ofs;
		!clear_n |=> almost_empty_distance == `DCF_OFS_RESET &&
			almost_full_distance == `DCF_OFS_RESET;
	endproperty
	a_default_ofs: assert property (p_default_ofs)
		else $error("offsets not at default after clear");

	property p_half;
		!cascade_mode && clear_n ##1 !cascade_mode |->
			over_half_n == !(count > CW'(DEPTH / 2));
	endproperty
	a_half: assert property (p_half)
		else $error("half flag disagrees with count");

	property p_replay;
		replay && clear_n |=> rd_ptr == '0;
	endproperty
	a_replay: assert property (p_replay)
		else $error("replay did not rewind read pointer");

	c_full: cover property (!no_room_n);
	c_replay: cover property (replay ##[1:8] pop_ok);
	c_ofs_read: cover property (!offset_load_n && !pop_enable_n);
	c_near_empty: cover property (!near_empty_n && nothing_stored_n);

endmodule : dcf_fifo

// File: bench/dcf_reader.sv
// reader-side logic model: sees read_word the way a shared bus would
// assumes read_word_o and read_word_oe come straight from the buffer
module dcf_reader import dcf_pkg::*;
(
	input wire logic sys_clk,
	input wire dcf_pkg::dcf_word_t read_word_o,
	input wire logic read_word_oe,
	output dcf_pkg::dcf_word_t bus_word
);
	timeunit 1ns;
	timeprecision 1ps;

	dcf_word_t last;

	always_ff @(posedge sys_clk)
	begin
		if (read_word_oe)
			last <= read_word_o;
	end

	// undriven bus shows inverted stale data so a float never looks valid
	assign bus_word = read_word_oe ? read_word_o : ~last;
endmodule : dcf_reader

// File: bench/tb_dcf_fifo.sv
// self-checking bench for the deep buffer: offsets, fill, drain, replay
// assumes a single sys_clk drives both the push and the pop side
module tb_dcf_fifo import dcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int D = 256;
	localparam int EO = 4;
	localparam int FO = 6;

	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clear_n = 1'b1;
	dcf_word_t write_word = '0;
	logic push_enable_n = 1'b1;
	logic pop_enable_n = 1'b1;
	logic offset_load_n = 1'b1;
	logic output_drive_enable_n = 1'b0;
	logic flag_sync_select = 1'b0;
	logic replay_strobe = 1'b0;
	logic cascade_mode = 1'b0;
	logic chain_head_n = 1'b0;
	logic push_token_in = 1'b1;
	logic pop_token_in = 1'b1;
	dcf_word_t read_word_o;
	dcf_word_t bus_word;
	logic read_word_oe;
	logic nothing_stored_n;
	logic no_room_n;
	logic near_empty_n;
	logic near_full_n;
	logic over_half_n;
	logic pop_token_out;
	logic [4:0] flg;
	int bad_count = 0;
	int compares = 0;

	// a lone device: its own empty and full flags are the combined ones
	assign flg = {nothing_stored_n, no_room_n, near_empty_n, near_full_n,
		over_half_n};

	always #2 sys_clk = ~sys_clk;

	dcf_fifo #(.DEPTH(D)) i_dcf_fifo (
		.sys_clk(sys_clk), .rst_n(rst_n), .clear_n(clear_n),
		.write_word(write_word), .push_enable_n(push_enable_n),
		.pop_enable_n(pop_enable_n), .offset_load_n(offset_load_n),
		.output_drive_enable_n(output_drive_enable_n),
		.flag_sync_select(flag_sync_select),
		.replay_strobe(replay_strobe), .cascade_mode(cascade_mode),
		.chain_head_n(chain_head_n), .push_token_in(push_token_in),
		.pop_token_in(pop_token_in),
		.read_word_o(read_word_o), .read_word_oe(read_word_oe),
		.nothing_stored_n(nothing_stored_n), .no_room_n(no_room_n),
		.near_empty_n(near_empty_n), .near_full_n(near_full_n),
		.over_half_n(over_half_n), .pop_token_out(pop_token_out)
	);

	dcf_reader i_dcf_reader (
		.sys_clk(sys_clk), .read_word_o(read_word_o),
		.read_word_oe(read_word_oe), .bus_word(bus_word)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [4:0] fl(input int c);
		return {c != 0, c != D, c > EO, (D - c) > FO, c <= D / 2};
	endfunction : fl

	function automatic dcf_word_t wd(input int i);
		return 18'h2a000 + 18'(i);
	endfunction : wd

	task automatic chk(input string n, input logic [17:0] got,
		input logic [17:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	// one request for one edge, then back to idle
	task automatic op(input logic p, input logic q, input logic l,
		input dcf_word_t w);
		@(posedge sys_clk);
		push_enable_n <= p;
		pop_enable_n <= q;
		offset_load_n <= l;
		write_word <= w;
		@(posedge sys_clk);
		push_enable_n <= 1'b1;
		pop_enable_n <= 1'b1;
		offset_load_n <= 1'b1;
		#1;
	endtask : op

	task automatic finish_test;
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		finish_test;
	end

	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk("flags", 18'(flg), 18'(fl(0)));
		chk("read_word", read_word_o, 18'h00000);
		chk("oe", 18'(read_word_oe), 18'h00001);
		for (int i = 0; i < 2; i++)
		begin
			op(1'b1, 1'b0, 1'b0, '0);
			chk("offset", read_word_o, 18'h0007f);
		end
		op(1'b0, 1'b1, 1'b0, 18'(EO));
		op(1'b0, 1'b1, 1'b0, 18'(FO));
		op(1'b1, 1'b0, 1'b0, '0);
		chk("offset", read_word_o, 18'(EO));
		op(1'b1, 1'b0, 1'b0, '0);
		chk("offset", read_word_o, 18'(FO));
		@(posedge sys_clk);
		flag_sync_select <= 1'b1;
		for (int i = 1; i <= D; i++)
		begin
			op(1'b0, 1'b1, 1'b1, wd(i));
			chk("flags", 18'(flg), 18'(fl(i)));
		end
		op(1'b0, 1'b1, 1'b1, 18'h3ffff);
		chk("flags", 18'(flg), 18'(fl(D)));
		@(posedge sys_clk);
		output_drive_enable_n <= 1'b1;
		#1;
		chk("oe", 18'(read_word_oe), 18'h00000);
		@(posedge sys_clk);
		output_drive_enable_n <= 1'b0;
		flag_sync_select <= 1'b0;
		for (int i = 1; i <= D; i++)
		begin
			op(1'b1, 1'b0, 1'b1, '0);
			chk("bus", bus_word, wd(i));
			chk("flags", 18'(flg), 18'(fl(D - i)));
		end
		op(1'b1, 1'b0, 1'b1, '0);
		chk("bus", bus_word, wd(D));
		// clear with push and pop idle throughout
		@(posedge sys_clk);
		clear_n <= 1'b0;
		@(posedge sys_clk);
		clear_n <= 1'b1;
		#1;
		chk("flags", 18'(flg), 18'(fl(0)));
		chk("read_word", read_word_o, 18'h00000);
		for (int i = 1; i <= 3; i++)
			op(1'b0, 1'b1, 1'b1, wd(i));
		op(1'b1, 1'b0, 1'b1, '0);
		chk("bus", bus_word, wd(1));
		// replay after pushes and a pop, then idle for recovery
		@(posedge sys_clk);
		replay_strobe <= 1'b1;
		@(posedge sys_clk);
		replay_strobe <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("flags", 18'(flg), 18'(fl(3)));
		op(1'b1, 1'b0, 1'b1, '0);
		chk("bus", bus_word, wd(1));
		// chained and not first: nothing moves until the tokens arrive
		@(posedge sys_clk);
		clear_n <= 1'b0;
		cascade_mode <= 1'b1;
		chain_head_n <= 1'b1;
		@(posedge sys_clk);
		clear_n <= 1'b1;
		op(1'b0, 1'b1, 1'b1, wd(0));
		chk("empty", 18'(nothing_stored_n), 18'h00000);
		chk("oe", 18'(read_word_oe), 18'h00000);
		@(posedge sys_clk);
		push_token_in <= 1'b0;
		pop_token_in <= 1'b0;
		@(posedge sys_clk);
		push_token_in <= 1'b1;
		pop_token_in <= 1'b1;
		for (int i = 1; i <= D; i++)
			op(1'b0, 1'b1, 1'b1, wd(i));
		chk("push_token", 18'(over_half_n), 18'h00000);
		for (int i = 1; i <= D; i++)
		begin
			op(1'b1, 1'b0, 1'b1, '0);
			chk("read_word", read_word_o, wd(i));
		end
		chk("pop_token", 18'(pop_token_out), 18'h00000);
		chk("oe", 18'(read_word_oe), 18'h00000);
		@(posedge sys_clk);
		#1;
		chk("pop_token", 18'(pop_token_out), 18'h00001);
		finish_test;
	end
endmodule : tb_dcf_fifo
